// *** rtl/sram_port_defs.svh ***
// sizes and reset values of the flow-through burst sram port
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH

`define SP_ADDR_W      19
`define SP_DEPTH       524288
`define SP_DATA_W      16
`define SP_LANES       2
`define SP_LANE_W      9
`define SP_BYTE_W      8
`define SP_BURST_W     2
`define SP_BUF_DEPTH   2
`define SP_BUF_W       39
`define SP_RST_ADDR    19'h00000
`define SP_RST_BURST   2'h0
`define SP_RST_LANES   2'h0

`endif

// *** rtl/sram_port_pkg.sv ***
// types shared by the sram port design
package sram_port_pkg;
  // operation held from the last qualified edge
  typedef enum logic [1:0] {
    st_idle,
    st_read,
    st_write
  } op_t;
endpackage : sram_port_pkg

// *** rtl/sync_flowthrough_sram_port.sv ***
// synchronous flow-through burst sram: control, burst counter, array and pin direction
`timescale 1ns/1ps
`include "sram_port_defs.svh"

module sync_flowthrough_sram_port
  import sram_port_pkg::*;
(
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_srst,
  input  wire logic [`SP_ADDR_W-1:0]   i_addr,
  input  wire logic                    i_advance_load,
  input  wire logic                    i_write_n,
  input  wire logic [`SP_LANES-1:0]    i_byte_lane_write_n,
  input  wire logic                    i_select_one_n,
  input  wire logic                    i_select_two,
  input  wire logic                    i_select_three_n,
  input  wire logic                    i_clock_qualify_n,
  input  wire logic                    i_output_enable_n,
  input  wire logic                    i_burst_mode,
  input  wire logic [`SP_DATA_W-1:0]   i_dq,
  input  wire logic [`SP_LANES-1:0]    i_parity_io,
  output logic      [`SP_DATA_W-1:0]   o_dq,
  output logic                         o_dq_oe,
  output logic      [`SP_LANES-1:0]    o_parity_io,
  output logic                         o_parity_oe,
  output logic                         o_write_ready
);

  logic                    oe_meta_r;
  logic                    oe_sync_r;
  logic                    mode_meta_r;
  logic                    mode_sync_r;
  logic                    interleave_r;
  op_t                     state_r;
  op_t                     state_nxt;
  op_t                     cur_state;
  logic                    first_r;
  logic                    first_nxt;
  logic                    cur_first;
  logic [`SP_ADDR_W-1:0]   base_r;
  logic [`SP_BURST_W-1:0]  start_r;
  logic [`SP_BURST_W-1:0]  cnt_r;
  logic [`SP_BURST_W-1:0]  cnt_nxt;
  logic [`SP_BURST_W-1:0]  low_nxt;
  logic [`SP_ADDR_W-1:0]   addr_nxt;
  logic [`SP_ADDR_W-1:0]   wr_addr_r;
  logic [`SP_LANES-1:0]    wr_lanes_r;
  logic                    oe_r;
  logic                    qual;
  logic                    selected;
  logic                    load;
  logic                    step;
  logic                    reading;
  logic                    buf_in_valid;
  logic                    buf_in_ready;
  logic [`SP_BUF_W-1:0]    buf_in_data;
  logic                    buf_out_valid;
  logic                    buf_out_ready;
  logic [`SP_BUF_W-1:0]    buf_out_data;
  logic [`SP_ADDR_W-1:0]   drain_addr;
  logic [`SP_LANES-1:0]    drain_lanes;
  logic [`SP_LANE_W-1:0]   rd_lane_r [0:`SP_LANES-1];

  // output enable is asynchronous: two flops before any logic
  always_ff @(posedge i_clk_sys) begin
    oe_meta_r <= i_output_enable_n;
    oe_sync_r <= oe_meta_r;
  end

  // the burst strap is static, synchronised then held after reset
  always_ff @(posedge i_clk_sys) begin
    mode_meta_r <= i_burst_mode;
    mode_sync_r <= mode_meta_r;
  end

  // strap caught while reset is held, frozen afterwards
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      interleave_r <= mode_sync_r;
    end
  end

  // qualify, select decode and load/advance decisions
  assign qual     = !i_clock_qualify_n;
  assign selected = !i_select_one_n && i_select_two && !i_select_three_n;
  assign load     = qual && !i_advance_load;
  assign step     = qual && i_advance_load && (state_r != st_idle);

  // burst address: wraps inside two bits, upper bits untouched
  always_comb begin
    cnt_nxt = cnt_r + 1'b1;
    if (interleave_r) begin
      low_nxt = start_r ^ cnt_nxt;
    end else begin
      low_nxt = start_r + cnt_nxt;
    end
    if (load) begin
      addr_nxt = i_addr;
    end else begin
      addr_nxt = {base_r[`SP_ADDR_W-1:`SP_BURST_W], low_nxt};
    end
  end

  // next operation; an advance while deselected stays deselected
  always_comb begin
    state_nxt = state_r;
    if (load) begin
      if (!selected) begin
        state_nxt = st_idle;
      end else if (!i_write_n) begin
        state_nxt = st_write;
      end else begin
        state_nxt = st_read;
      end
    end
    first_nxt = (state_r == st_idle) && (state_nxt != st_idle);
  end

  // values that hold for the cycle now starting; masked edges keep the old ones
  assign cur_state = qual ? state_nxt : state_r;
  assign cur_first = qual ? first_nxt : first_r;

  // operation state only moves on qualified edges
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_r <= st_idle;
      first_r <= 1'b0;
    end else if (qual) begin
      state_r <= state_nxt;
      first_r <= first_nxt;
    end
  end

  // address base and burst counter
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      base_r  <= `SP_RST_ADDR;
      start_r <= `SP_RST_BURST;
      cnt_r   <= `SP_RST_BURST;
    end else if (load) begin
      base_r  <= i_addr;
      start_r <= i_addr[`SP_BURST_W-1:0];
      cnt_r   <= `SP_RST_BURST;
    end else if (step) begin
      cnt_r   <= cnt_nxt;
    end
  end

  // write command: address and lane selects wait for the data phase
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wr_addr_r  <= `SP_RST_ADDR;
      wr_lanes_r <= `SP_RST_LANES;
    end else if (qual && (state_nxt == st_write)) begin
      wr_addr_r  <= addr_nxt;
      wr_lanes_r <= ~i_byte_lane_write_n;
    end
  end

  // data phase word goes into the buffer; the host watches o_write_ready
  assign buf_in_valid = qual && (state_r == st_write);
  assign buf_in_data  = {wr_addr_r, wr_lanes_r, i_parity_io, i_dq};
  assign reading      = qual && (state_nxt == st_read);
  // single-ported array: a read takes the port, the write drain waits
  assign buf_out_ready = !reading;
  assign drain_addr    = buf_out_data[`SP_BUF_W-1 -: `SP_ADDR_W];
  assign drain_lanes   = buf_out_data[`SP_DATA_W+`SP_LANES +: `SP_LANES];

  two_entry_buffer #(
    .WIDTH (`SP_BUF_W),
    .DEPTH (`SP_BUF_DEPTH)
  ) u_write_buf (
    .i_clk_sys   (i_clk_sys),
    .i_srst      (i_srst),
    .i_in_valid  (buf_in_valid),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (buf_in_data),
    .o_out_valid (buf_out_valid),
    .i_out_ready (buf_out_ready),
    .o_out_data  (buf_out_data)
  );

  // one array per byte lane, each holding the byte and its parity bit
  for (genvar lane = 0; lane < `SP_LANES; lane++) begin : g_lane
    logic [`SP_LANE_W-1:0] mem [0:`SP_DEPTH-1];

    // drain writes only the lanes that were selected with the strobe
    always_ff @(posedge i_clk_sys) begin
      if (buf_out_valid && buf_out_ready && drain_lanes[lane]) begin
        mem[drain_addr] <= {buf_out_data[`SP_DATA_W+lane],
                            buf_out_data[lane*`SP_BYTE_W +: `SP_BYTE_W]};
      end
    end

    // flow-through read: word for the address taken at this edge
    always_ff @(posedge i_clk_sys) begin
      if (reading) begin
        rd_lane_r[lane] <= mem[addr_nxt];
      end
    end

    assign o_dq[lane*`SP_BYTE_W +: `SP_BYTE_W] = rd_lane_r[lane][`SP_BYTE_W-1:0];
    assign o_parity_io[lane]                     = rd_lane_r[lane][`SP_BYTE_W];
  end

  // pin direction: drive only in a read, not its first cycle after idle, with oe low
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= (cur_state == st_read) && !cur_first && !oe_sync_r;
    end
  end

  assign o_dq_oe       = oe_r;
  assign o_parity_oe   = oe_r;
  assign o_write_ready = buf_in_ready;

  // checks next to the logic they guard
  chk_deselect_float: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (load && !selected) |=> !o_dq_oe && !o_parity_oe)
    else $error("data pins driven while deselected");

  chk_write_float: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (qual && state_nxt == st_write) |=> !o_dq_oe)
    else $error("data pins driven during write");

  chk_first_float: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (load && selected && i_write_n && state_r == st_idle) |=> !o_dq_oe)
    else $error("data pins driven on first cycle after deselect");

  chk_oe_high_float: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_output_enable_n [*3] |=> !o_dq_oe)
    else $error("data pins driven with output enable high");

  chk_read_drives: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (state_r == st_read && !first_r && !oe_sync_r && !qual) |=> o_dq_oe)
    else $error("read with output enable low not driving");

  chk_suspend_holds: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_clock_qualify_n |=> $stable(state_r) && $stable(base_r) && $stable(cnt_r) && $stable(o_dq))
    else $error("state moved on a masked edge");

  chk_load_address: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    load |=> base_r == $past(i_addr) && cnt_r == 2'h0 && start_r == base_r[1:0])
    else $error("address not loaded");

  chk_burst_wrap: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    step |=> cnt_r == ($past(cnt_r) + 2'h1) && $stable(base_r))
    else $error("burst counter did not step");

  chk_interleave_order: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (step && interleave_r) |-> addr_nxt[1:0] == (start_r ^ (cnt_r + 2'h1)))
    else $error("interleaved burst address wrong");

  chk_write_strobe: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (load && selected && i_write_n) |=> state_r == st_read ##0 $stable(wr_lanes_r))
    else $error("write lanes changed without write strobe");

  chk_select_decode: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (load && (i_select_one_n || !i_select_two || i_select_three_n)) |=> state_r == st_idle)
    else $error("load while deselected left an access open");

  chk_write_start: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (load && selected && !i_write_n) |=> state_r == st_write)
    else $error("qualified write load did not start a write");

  chk_masked_write_hold: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_clock_qualify_n |=> $stable(wr_addr_r) && $stable(wr_lanes_r) && $stable(first_r))
    else $error("write command state moved on a masked edge");

  chk_idle_advance: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (qual && i_advance_load && state_r == st_idle) |=> state_r == st_idle && $stable(cnt_r))
    else $error("advance while deselected changed the burst");

endmodule : sync_flowthrough_sram_port

// *** rtl/two_entry_buffer.sv ***
// small valid/ready buffer for the pending write words
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 2
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_srst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store_r [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             in_ready_r;
  logic             push;
  logic             pop;

  // ready is a flop so the host sees a clean level; empty from the count
  assign o_in_ready  = in_ready_r;
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = store_r[rd_ptr_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // storage has no reset; the pointers, count and ready do
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      store_r[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers wrap at the depth
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // occupancy, push and pop in one cycle cancel
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ready computed from the next count, so it tracks count_r exactly
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      in_ready_r <= 1'b1;
    end else begin
      in_ready_r <= (count_nxt != CNT_W'(DEPTH));
    end
  end
endmodule : two_entry_buffer

// *** test/sram_host_model.sv ***
// host controller model that drives the sram port pins
`timescale 1ns/1ps
module sram_host_model (
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_dev_dq,
  input  wire logic [1:0]  i_dev_par,
  input  wire logic        i_dev_oe,
  output logic [18:0]      o_addr,
  output logic             o_adv,
  output logic             o_write_n,
  output logic [1:0]       o_lane_n,
  output logic [2:0]       o_sel,
  output logic             o_qual_n,
  output logic [15:0]      o_dq,
  output logic [1:0]       o_par
);
  logic [17:0] drv   = 18'h3FFFF;
  logic        wr_op = 1'b0;

  // shared data lines: device drive wins, host value otherwise
  assign {o_par, o_dq} = i_dev_oe ? {i_dev_par, i_dev_dq} : drv;

  // idle as a deselected no-op from time zero
  initial begin
    o_addr    = 19'h00000;
    o_adv     = 1'b0;
    o_write_n = 1'b1;
    o_lane_n  = 2'h3;
    o_sel     = 3'h6;
    o_qual_n  = 1'b0;
  end

  // one bus cycle, launched at the edge and held until the next one
  task automatic cyc(input logic adv, input logic wn, input logic [2:0] sel, input logic [18:0] a,
                     input logic [1:0] ln, input logic [17:0] d, input logic qn);
    @(posedge i_clk_sys);
    o_adv     <= adv;
    o_write_n <= wn;
    o_lane_n  <= ln;
    o_sel     <= sel;
    o_addr    <= a;
    o_qual_n  <= qn;
    drv       <= wr_op ? d : ~drv;  // released lines flip, a stale word never reads back
    if (!qn && !adv) begin
      wr_op <= (sel == 3'h2) && !wn;
    end
  endtask : cyc
endmodule : sram_host_model

// *** test/sync_flowthrough_sram_port_bench.sv ***
// self-checking bench for the flow-through sram port
`timescale 1ns/1ps
module sync_flowthrough_sram_port_bench;
  logic        clk  = 1'b0;
  logic        srst = 1'b1;
  logic        oe_n = 1'b0;
  logic        mode = 1'b0;
  logic        adv, wn, qn, oe, poe, wready;
  logic [18:0] addr;
  logic [2:0]  sel;
  logic [1:0]  ln, bpar, par;
  logic [15:0] bdq, dq;
  logic [17:0] mem [int];
  int          err_count = 0;
  int          cmp_count = 0;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  sync_flowthrough_sram_port DUT (
    .i_clk_sys(clk), .i_srst(srst), .i_addr(addr), .i_advance_load(adv), .i_write_n(wn),
    .i_byte_lane_write_n(ln), .i_select_one_n(sel[2]), .i_select_two(sel[1]), .i_select_three_n(sel[0]),
    .i_clock_qualify_n(qn), .i_output_enable_n(oe_n), .i_burst_mode(mode), .i_dq(bdq), .i_parity_io(bpar),
    .o_dq(dq), .o_dq_oe(oe), .o_parity_io(par), .o_parity_oe(poe), .o_write_ready(wready)
  );

  sram_host_model host (
    .i_clk_sys(clk), .i_dev_dq(dq), .i_dev_par(par), .i_dev_oe(oe), .o_addr(addr), .o_adv(adv),
    .o_write_n(wn), .o_lane_n(ln), .o_sel(sel), .o_qual_n(qn), .o_dq(bdq), .o_par(bpar)
  );

  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one cycle; afterwards the outputs show what the previous command produced
  task automatic cy(input logic v, input logic w, input logic [2:0] s, input logic [18:0] a,
                    input logic [1:0] l, input logic [17:0] d, input logic q);
    host.cyc(v, w, s, a, l, d, q);
    #1;
  endtask : cy

  task automatic idle(input int n);
    repeat (n) cy(1'b0, 1'b1, 3'h6, 19'h00000, 2'h3, 18'h00000, 1'b0);
  endtask : idle

  // low burst bits: linear adds the step, interleaved xors it, upper bits fixed
  function automatic logic [18:0] baddr(input logic [18:0] a, input int k, input logic il);
    baddr = {a[18:2], il ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
  endfunction : baddr

  function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] d, input logic [1:0] l);
    merge = o;
    if (!l[0]) {merge[16], merge[7:0]} = {d[16], d[7:0]};
    if (!l[1]) {merge[17], merge[15:8]} = {d[17], d[15:8]};
  endfunction : merge

  // strap is only taken while reset is high
  task automatic do_reset(input logic m);
    @(posedge clk);
    srst <= 1'b1;
    mode <= m;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("write ready", 18'(wready), 18'h00001);
  endtask : do_reset

  task automatic wrb(input logic [18:0] a, input int n, input logic il, input logic [1:0] l,
                     input logic [17:0] b);
    logic [18:0] w;
    cy(1'b0, 1'b0, 3'h2, a, l, 18'h00000, 1'b0);
    for (int k = 1; k <= n; k++) begin
      w = baddr(a, k - 1, il);
      mem[w] = merge(mem[w], b + 18'(k), l);
      if (k < n) cy(1'b1, 1'b0, 3'h2, a, l, b + 18'(k), 1'b0);
      else cy(1'b0, 1'b1, 3'h6, a, 2'h3, b + 18'(k), 1'b0);
      chk("write oe", {16'h0000, poe, oe}, 18'h00000);
    end
    idle(3);
  endtask : wrb

  // q puts a masked edge into the burst, which must hold the word
  task automatic rd(input logic [18:0] a, input int n, input logic il, input logic e, input logic q);
    cy(1'b0, 1'b1, 3'h2, a, 2'h3, 18'h00000, 1'b0);
    for (int k = 1; k <= n; k++) begin
      if (q && k == 2) cy(1'b1, 1'b1, 3'h2, a, 2'h3, 18'h00000, 1'b1);
      if (k < n) cy(1'b1, 1'b1, 3'h2, a, 2'h3, 18'h00000, 1'b0);
      else cy(1'b0, 1'b1, 3'h6, a, 2'h3, 18'h00000, 1'b0);
      chk("read data", {par, dq}, mem[baddr(a, k - 1, il)]);
      chk("read oe", {16'h0000, poe, oe}, {16'h0000, {2{e && k > 1}}});
    end
    idle(1);
    chk("idle oe", {16'h0000, poe, oe}, 18'h00000);
  endtask : rd

  task automatic t_burst(input logic il);
    do_reset(il);
    mem.delete();
    wrb(19'h12345, 4, il, 2'h0, 18'h05500);
    rd(19'h12345, 4, il, 1'b1, 1'b0);
    rd(19'h12345, 4, il, 1'b1, 1'b1);
    // single loads expose the order the burst really wrote in
    for (int k = 0; k < 4; k++) rd(19'h12344 + 19'(k), 1, il, 1'b1, 1'b0);
  endtask : t_burst

  task automatic t_lanes;
    wrb(19'h00100, 2, 1'b0, 2'h0, 18'h10000);
    wrb(19'h00100, 2, 1'b0, 2'h2, 18'h2A5A0);
    wrb(19'h00101, 1, 1'b0, 2'h1, 18'h15AA0);
    wrb(19'h00100, 2, 1'b0, 2'h3, 18'h3FFF0);
    rd(19'h00100, 2, 1'b0, 1'b1, 1'b0);
  endtask : t_lanes

  // every select pattern, then a write load on a masked edge
  task automatic t_select;
    logic [17:0] d;
    wrb(19'h7FFFC, 1, 1'b0, 2'h0, 18'h0ABC0);
    for (int s = 0; s < 8; s++) begin
      d = 18'h20000 + 18'(s);
      cy(1'b0, 1'b0, 3'(s), 19'h7FFFC, 2'h0, d, 1'b0);
      cy(1'b0, 1'b1, 3'h6, 19'h7FFFC, 2'h3, d, 1'b0);
      chk("select oe", {16'h0000, poe, oe}, 18'h00000);
      if (s == 2) mem[19'h7FFFC] = d;
    end
    cy(1'b0, 1'b0, 3'h2, 19'h7FFFC, 2'h0, 18'h3C3C3, 1'b1);
    idle(3);
    cy(1'b1, 1'b1, 3'h2, 19'h7FFFC, 2'h3, 18'h00000, 1'b0);
    rd(19'h7FFFC, 1, 1'b0, 1'b1, 1'b0);
  endtask : t_select

  task automatic t_oe;
    @(posedge clk);
    oe_n <= 1'b1;
    idle(4);
    rd(19'h12346, 4, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    oe_n <= 1'b0;
    idle(4);
    rd(19'h12346, 4, 1'b0, 1'b1, 1'b0);
  endtask : t_oe

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // linear order last so the later tests read in linear order
  initial begin
    t_burst(1'b1);
    t_burst(1'b0);
    t_lanes();
    t_select();
    t_oe();
    complete_run();
  end

  // whole run is about 150 cycles; this cuts a hang
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule : sync_flowthrough_sram_port_bench
